// ### port_status_pkg.sv
// Constants and types shared by the port status and interrupt summary block.
package port_status_pkg;

    // ==========================================================
    // Register indices and byte addresses
    // ==========================================================
    localparam int unsigned       STATUS_IDX   = 24;
    localparam int unsigned       SUMMARY_IDX  = 20;
    localparam int unsigned       MASK_IDX     = 21;
    localparam logic [11:0]       STATUS_ADDR  = 12'(STATUS_IDX * 4);
    localparam logic [11:0]       SUMMARY_ADDR = 12'(SUMMARY_IDX * 4);
    localparam logic [11:0]       MASK_ADDR    = 12'(MASK_IDX * 4);

    // ==========================================================
    // Per-port status register fields
    // ==========================================================
    localparam int unsigned       SD_BIT       = 14;
    localparam int unsigned       TXACT_BIT    = 13;
    localparam int unsigned       RXACT_BIT    = 12;
    localparam int unsigned       FD_BIT       = 11;
    localparam int unsigned       LINK_BIT     = 10;
    localparam int unsigned       S100_BIT     = 9;
    localparam int unsigned       S10_BIT      = 8;
    localparam int unsigned       BLINK_BIT    = 3;
    localparam int unsigned       SEL_MSB      = 2;
    localparam logic [2:0]        SEL_PORT0    = 3'h0;
    localparam logic [2:0]        SEL_PORT1    = 3'h1;
    localparam int unsigned       NUM_PORTS    = 2;
    // Live status per port: {sd, fd, link, s100, s10}.
    localparam logic [4:0]        LIVE_RESET   = 5'h0A;

    // ==========================================================
    // Interrupt summary fields
    // ==========================================================
    localparam int unsigned       CAP_FULL_BIT = 12;
    localparam logic [15:0]       STICKY_BITS  = 16'hE7FF;
    localparam logic [15:0]       TIMING_BITS  = 16'hF700;
    localparam logic [15:0]       MASK_RW_BITS = 16'hF7FF;
    localparam logic [15:0]       SUMMARY_RESET = 16'h0000;
    localparam logic [15:0]       MASK_RESET   = 16'h0000;

    // ==========================================================
    // Activity blink timing
    // ==========================================================
    localparam int unsigned       CLK_MHZ      = 100;
    localparam int unsigned       BLINK_HALF_US = 40000;
    localparam int unsigned       BLINK_HALF_CYCLES = BLINK_HALF_US * CLK_MHZ;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_t;

endpackage : port_status_pkg

// ### sticky_flags.sv
// Bank of sticky event flags where a set always beats a clear.
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
    parameter int unsigned W = 4
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output var  logic [W-1:0] flags
);
    logic [W-1:0] next_flags;

    always_comb begin
        next_flags = (flags & ~clr) | set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end
endmodule : sticky_flags
`default_nettype wire

// ### activity_led.sv
// Link LED driver for one port with optional blink on activity.
`timescale 1ns/1ps
`default_nettype none
module activity_led #(
    parameter int unsigned HALF_CYCLES = 4000000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic blink_enable,
    input  wire logic link_up,
    input  wire logic activity,
    input  wire logic gpio_link_mode,
    output var  logic link_led,
    output var  logic gpio_led_n
);
    logic [31:0] count;
    logic        phase;
    logic        seen;
    logic [31:0] next_count;
    logic        next_phase;
    logic        next_seen;
    logic        next_led;
    logic        next_gpio_n;
    logic        wrap;

    always_comb begin
        wrap       = (count == 32'(HALF_CYCLES - 1));
        next_count = wrap ? 32'h0 : count + 32'h1;
        next_phase = wrap ? ~phase : phase;
        // Activity is held until the end of the off half in progress or of the next one.
        next_seen  = activity | (seen & ~(wrap & phase));
        next_led   = link_up & ~(blink_enable & seen & phase);
        // A pin in LED use sinks current, so lit is low.
        next_gpio_n = ~(gpio_link_mode & next_led);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count      <= 32'h0;
            phase      <= 1'b0;
            seen       <= 1'b0;
            link_led   <= 1'b0;
            gpio_led_n <= 1'b1;
        end else begin
            count      <= next_count;
            phase      <= next_phase;
            seen       <= next_seen;
            link_led   <= next_led;
            gpio_led_n <= next_gpio_n;
        end
    end
endmodule : activity_led
`default_nettype wire

// ### port_status_top.sv
// APB register bank for per-port status, activity blink and interrupt summary.
//
// Summary of operation
// - Selector 000 shows port 0, 001 port 1; others are reserved.
// - Bit 14 shows the selected port's signal detect, resets to zero.
// - Bit 13 latches transmit activity since last read, cleared by reading.
// - Bit 12 latches receive activity since last read, cleared by reading.
// - Bit 11 full duplex resets one; bit 10 link up resets zero.
// - Bit 9 shows 100 Mbit/s, resets one; bit 8 shows 10 Mbit/s.
// - Blink bit one makes the link LED blink on activity, on with link.
// - A blink write only updates the port named by the selector.
// - A pin set for link indication blinks during transfers when enabled.
// - Summary bits set only for sources enabled at their origin.
// - Bits 15 and 9: port 1 and 0 receive timestamps, clear on read.
// - Bits 14 and 8: port 1 and 0 transmit timestamps, clear on read.
// - Bit 13 capture stored, clear on read; bit 12 capture full level.
// - Bit 10 pulse period start, clear on read; bit 11 reads zero.
// - Bits 7 and 3: port 1 and 0 link down, clear on read.
// - Bits 6 and 2: port 1 and 0 error rate, clear on read.
// - Bits 5 and 1: port 1 and 0 far-end quality, clear on read.
// - Bits 4 and 0: port 1 and 0 other events, clear on read.
// - Central mask register: zero enables, one disables, resets to zero.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module port_status_top
    import port_status_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYCLES,
    parameter bit          HAS_TIMING   = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic [1:0]  signal_detect,
    input  wire logic [1:0]  full_duplex,
    input  wire logic [1:0]  link_up,
    input  wire logic [1:0]  speed_hundred,
    input  wire logic [1:0]  speed_ten,
    input  wire logic [1:0]  tx_activity,
    input  wire logic [1:0]  rx_activity,
    input  wire logic [1:0]  gpio_link_mode,
    input  wire logic [15:0] summary_source,
    input  wire logic [15:0] source_enable,
    output var  logic [1:0]  link_led,
    output var  logic [1:0]  gpio_led_n,
    output var  logic        summary_pending
);

    // ==========================================================
    // Helper functions
    // ==========================================================
    function automatic logic sel_valid(input logic [2:0] s);
        sel_valid = (s == SEL_PORT0) || (s == SEL_PORT1);
    endfunction : sel_valid

    function automatic logic sel_port(input logic [2:0] s);
        sel_port = (s == SEL_PORT1);
    endfunction : sel_port

    // ==========================================================
    // Declarations
    // ==========================================================
    bus_state_t  state;
    bus_state_t  next_state;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        done;
    logic        wr_done;
    logic        rd_done;
    logic [15:0] rd_snap;
    logic [15:0] next_rd_snap;
    logic [1:0]  rd_kind;
    logic [1:0]  next_rd_kind;

    logic [2:0]  port_selector;
    logic [2:0]  next_port_selector;
    logic [1:0]  activity_blink_enable;
    logic [1:0]  next_activity_blink_enable;
    logic [15:0] mask;
    logic [15:0] next_mask;

    logic [4:0]  live [NUM_PORTS];
    logic [4:0]  next_live [NUM_PORTS];

    logic [3:0]  act_set;
    logic [3:0]  act_clr;
    logic [3:0]  act_flags;

    logic [15:0] sum_gate;
    logic [15:0] sum_set;
    logic [15:0] sum_clr;
    logic [15:0] sum_flags;
    logic        cap_full;
    logic        next_cap_full;
    logic [15:0] sum_view;
    logic        next_pending;

    logic [15:0] status_view;
    logic        psel_port;

    // ==========================================================
    // Live status capture
    // ==========================================================
    // Held in flops so the fields show their reset values until the
    // port logic drives real ones.
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            next_live[p] = {signal_detect[p], full_duplex[p], link_up[p],
                            speed_hundred[p], speed_ten[p]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                live[p] <= LIVE_RESET;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                live[p] <= next_live[p];
            end
        end
    end

    // ==========================================================
    // Status register view
    // ==========================================================
    always_comb begin
        psel_port   = sel_port(port_selector);
        status_view = 16'h0000;
        if (sel_valid(port_selector)) begin
            status_view[SD_BIT]    = live[psel_port][4];
            status_view[TXACT_BIT] = act_flags[{psel_port, 1'b0}];
            status_view[RXACT_BIT] = act_flags[{psel_port, 1'b1}];
            status_view[FD_BIT]    = live[psel_port][3];
            status_view[LINK_BIT]  = live[psel_port][2];
            status_view[S100_BIT]  = live[psel_port][1];
            status_view[S10_BIT]   = live[psel_port][0];
            status_view[BLINK_BIT] = activity_blink_enable[psel_port];
        end
        status_view[SEL_MSB:0] = port_selector;
    end

    // ==========================================================
    // APB slave
    // ==========================================================
    // One wait state: the read value is snapshotted when the answer is
    // prepared, and only the snapshotted bits are cleared afterwards,
    // so an event landing in between is never lost.
    always_comb begin
        done         = psel & penable & pready;
        wr_done      = done & pwrite;
        rd_done      = done & ~pwrite;
        next_state   = state;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        next_prdata  = prdata;
        next_rd_snap = rd_snap;
        next_rd_kind = rd_kind;
        case (state)
            BUS_IDLE: begin
                if (psel && penable) begin
                    next_state   = BUS_ANSWER;
                    next_pready  = 1'b1;
                    next_prdata  = 32'h0;
                    next_rd_kind = 2'b00;
                    case (paddr)
                        STATUS_ADDR: begin
                            next_prdata  = {16'h0000, status_view};
                            next_rd_kind = 2'b01;
                        end
                        SUMMARY_ADDR: begin
                            next_prdata  = {16'h0000, sum_view};
                            next_rd_kind = 2'b10;
                        end
                        MASK_ADDR: begin
                            next_prdata  = {16'h0000, mask & MASK_RW_BITS};
                        end
                        default: begin
                            next_pslverr = 1'b1;
                        end
                    endcase
                    next_rd_snap = next_prdata[15:0];
                end
            end
            BUS_ANSWER: begin
                next_state = BUS_IDLE;
            end
            default: begin
                next_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= BUS_IDLE;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            rd_snap <= 16'h0000;
            rd_kind <= 2'b00;
        end else begin
            state   <= next_state;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            rd_snap <= next_rd_snap;
            rd_kind <= next_rd_kind;
        end
    end

    // ==========================================================
    // Writable control: selector, blink enables, mask
    // ==========================================================
    always_comb begin
        next_port_selector         = port_selector;
        next_activity_blink_enable = activity_blink_enable;
        next_mask                  = mask;
        if (wr_done && !pslverr && paddr == STATUS_ADDR) begin
            next_port_selector = pwdata[SEL_MSB:0];
            // The blink bit goes to the port named in the same write.
            if (sel_valid(pwdata[SEL_MSB:0])) begin
                next_activity_blink_enable[sel_port(pwdata[SEL_MSB:0])] =
                    pwdata[BLINK_BIT];
            end
        end
        if (wr_done && !pslverr && paddr == MASK_ADDR) begin
            next_mask = pwdata[15:0] & MASK_RW_BITS;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_selector         <= SEL_PORT0;
            activity_blink_enable <= 2'b00;
            mask                  <= MASK_RESET;
        end else begin
            port_selector         <= next_port_selector;
            activity_blink_enable <= next_activity_blink_enable;
            mask                  <= next_mask;
        end
    end

    // ==========================================================
    // Activity flags
    // ==========================================================
    always_comb begin
        act_set = {rx_activity[1], tx_activity[1],
                   rx_activity[0], tx_activity[0]};
        act_clr = 4'h0;
        // Only the port shown by the finished read is cleared.
        if (rd_done && rd_kind == 2'b01 && sel_valid(rd_snap[SEL_MSB:0])) begin
            act_clr[{sel_port(rd_snap[SEL_MSB:0]), 1'b0}] = rd_snap[TXACT_BIT];
            act_clr[{sel_port(rd_snap[SEL_MSB:0]), 1'b1}] = rd_snap[RXACT_BIT];
        end
    end

    sticky_flags #(
        .W (4)
    ) u_act_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (act_set),
        .clr     (act_clr),
        .flags   (act_flags)
    );

    // ==========================================================
    // Interrupt summary
    // ==========================================================
    always_comb begin
        sum_gate = summary_source & source_enable;
        if (!HAS_TIMING) begin
            sum_gate = sum_gate & ~TIMING_BITS;
        end
        // Bits 15:13, 10:0 latch; bit 11 has no source and stays zero.
        sum_set       = sum_gate & STICKY_BITS;
        next_cap_full = sum_gate[CAP_FULL_BIT];
        sum_clr       = 16'h0000;
        if (rd_done && rd_kind == 2'b10) begin
            sum_clr = rd_snap & STICKY_BITS;
        end
        sum_view = sum_flags | (16'(cap_full) << CAP_FULL_BIT);
        next_pending = |(sum_view & ~mask);
    end

    sticky_flags #(
        .W (16)
    ) u_sum_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (sum_set),
        .clr     (sum_clr),
        .flags   (sum_flags)
    );

    // Capture-full is a level from the timing unit, so it is only
    // registered here and a read never clears it.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_full        <= 1'b0;
            summary_pending <= 1'b0;
        end else begin
            cap_full        <= next_cap_full;
            summary_pending <= next_pending;
        end
    end

    // ==========================================================
    // Link LEDs
    // ==========================================================
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_led
        activity_led #(
            .HALF_CYCLES (BLINK_CYCLES)
        ) u_led (
            .pclk           (pclk),
            .presetn        (presetn),
            .blink_enable   (activity_blink_enable[p]),
            .link_up        (live[p][2]),
            .activity       (tx_activity[p] | rx_activity[p]),
            .gpio_link_mode (gpio_link_mode[p]),
            .link_led       (link_led[p]),
            .gpio_led_n     (gpio_led_n[p])
        );
    end

endmodule : port_status_top
`default_nettype wire

// ### port_status_checker.sv
// Bus protocol and register view assertions for the port status block.
`timescale 1ns/1ps
`default_nettype none
module port_status_checker
    import port_status_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  link_up,
    input wire logic [1:0]  link_led,
    input wire logic        summary_pending
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic mapped;
    logic rd_stat;
    logic rd_sum;
    assign mapped  = (paddr == STATUS_ADDR) || (paddr == SUMMARY_ADDR) || (paddr == MASK_ADDR);
    assign rd_stat = pready && !pwrite && (paddr == STATUS_ADDR);
    assign rd_sum  = pready && !pwrite && (paddr == SUMMARY_ADDR);

    // ==========================================================
    // Bus handshake
    // ==========================================================
    answer_delay_a: assert property (psel && penable && !pready |=> pready) else $error("late answer");
    single_pulse_a: assert property (pready |=> !pready) else $error("answer held too long");
    answer_access_a: assert property (pready |-> psel && penable) else $error("answer outside access");
    error_unmapped_a: assert property (pready |-> pslverr == !mapped) else $error("wrong error response");
    error_zero_a: assert property (pready && pslverr |-> prdata == 32'h00000000) else $error("error data not zero");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper half not zero");

    // ==========================================================
    // Register view and link LED
    // ==========================================================
    status_reserved_a: assert property (rd_stat |-> !prdata[15] && prdata[7:4] == 4'h0) else $error("status gap set");
    bad_select_a: assert property (rd_stat && prdata[2:1] != 2'b00 |-> prdata[15:3] == 13'h0000) else $error("bad select");
    summary_gap_a: assert property (rd_sum |-> !prdata[11]) else $error("summary bit 11 set");
    led_dark_a: assert property (!link_up[0] [*4] |-> !link_led[0]) else $error("led lit without link");

    cover property (pready && pslverr);
    cover property (rd_sum && prdata[15:0] != 16'h0000);
    cover property (summary_pending);
endmodule : port_status_checker

bind port_status_top port_status_checker chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_up(link_up), .link_led(link_led),
    .summary_pending(summary_pending)
);
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the port status and interrupt summary block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import port_status_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic        pready, pslverr, summary_pending, err;
    logic [1:0]  signal_detect = 2'h0, full_duplex = 2'h3, link_up = 2'h0, speed_hundred = 2'h3;
    logic [1:0]  speed_ten = 2'h0, tx_activity = 2'h0, rx_activity = 2'h0, gpio_link_mode = 2'h0;
    logic [1:0]  link_led, gpio_led_n;
    logic [15:0] summary_source = 16'h0000, source_enable = 16'h0000, ev_pulse = 16'h0000;
    int          num_errors = 0, n_tests = 0;

    always #5 pclk = ~pclk;

    // A short blink period keeps the LED scenario to a few dozen cycles.
    port_status_top #(.BLINK_CYCLES(4), .HAS_TIMING(1'b1)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .signal_detect(signal_detect), .full_duplex(full_duplex), .link_up(link_up),
        .speed_hundred(speed_hundred), .speed_ten(speed_ten), .tx_activity(tx_activity),
        .rx_activity(rx_activity), .gpio_link_mode(gpio_link_mode), .summary_source(summary_source),
        .source_enable(source_enable), .link_led(link_led), .gpio_led_n(gpio_led_n),
        .summary_pending(summary_pending)
    );

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic final_report();
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Any bit set in ev_pulse is raised as a one-cycle event seen on the completing edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        bit done;
        done = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 16 && !done; i++) begin
            @(posedge pclk);
            summary_source <= (i == 0) ? (summary_source | ev_pulse) : (summary_source & ~ev_pulse);
            if (pready === 1'b1) begin
                done = 1'b1;
                rd = prdata;
                err = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!done) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, pready, 1'b1);
            final_report();
        end
    endtask : apb

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset();
        apb(1'b0, SUMMARY_ADDR, 16'h0000);
        chk(rd, 32'h00000000);
        apb(1'b0, MASK_ADDR, 16'h0000);
        chk(rd, 32'h00000000);
        apb(1'b0, STATUS_ADDR, 16'h0000);
        chk(rd, 32'h00000A00);
    endtask : t_reset

    task automatic t_select();
        signal_detect <= 2'b01;
        full_duplex <= 2'b10;
        link_up <= 2'b11;
        speed_hundred <= 2'b10;
        speed_ten <= 2'b01;
        apb(1'b1, STATUS_ADDR, 16'h0000);
        apb(1'b0, STATUS_ADDR, 16'h0000);
        chk(rd, 32'h00004500);
        apb(1'b1, STATUS_ADDR, 16'h0001);
        apb(1'b0, STATUS_ADDR, 16'h0000);
        chk(rd, 32'h00000E01);
        apb(1'b1, STATUS_ADDR, 16'h0002);
        apb(1'b0, STATUS_ADDR, 16'h0000);
        chk(rd, 32'h00000002);
    endtask : t_select

    task automatic t_activity();
        apb(1'b1, STATUS_ADDR, 16'h0000);
        tx_activity <= 2'b01;
        rx_activity <= 2'b10;
        @(posedge pclk);
        tx_activity <= 2'b00;
        rx_activity <= 2'b00;
        apb(1'b0, STATUS_ADDR, 16'h0000);
        chk(rd, 32'h00006500);
        apb(1'b0, STATUS_ADDR, 16'h0000);
        chk(rd, 32'h00004500);
        apb(1'b1, STATUS_ADDR, 16'h0001);
        apb(1'b0, STATUS_ADDR, 16'h0000);
        chk(rd, 32'h00001E01);
        apb(1'b0, STATUS_ADDR, 16'h0000);
        chk(rd, 32'h00000E01);
    endtask : t_activity

    task automatic t_blink();
        int d0 = 0;
        int d1 = 0;
        int g0 = 0;
        int g1 = 0;
        gpio_link_mode <= 2'b10;
        apb(1'b1, STATUS_ADDR, 16'h0009);
        apb(1'b0, STATUS_ADDR, 16'h0000);
        chk(rd, 32'h00000E09);
        apb(1'b1, STATUS_ADDR, 16'h0000);
        apb(1'b0, STATUS_ADDR, 16'h0000);
        chk(rd, 32'h00004500);
        tx_activity <= 2'b11;
        repeat (40) begin
            @(posedge pclk);
            d0 += (link_led[0] !== 1'b1);
            d1 += (link_led[1] === 1'b0);
            g0 += (gpio_led_n[0] !== 1'b1);
            g1 += (gpio_led_n[1] === 1'b0);
        end
        tx_activity <= 2'b00;
        chk(32'(d0), 32'h00000000);
        chk({31'h0, d1 > 0 && d1 < 40}, 32'h00000001);
        chk(32'(g0), 32'h00000000);
        chk({31'h0, g1 > 0 && g1 < 40}, 32'h00000001);
        link_up <= 2'b00;
        repeat (6) @(posedge pclk);
        chk({30'h0, link_led}, 32'h00000000);
    endtask : t_blink

    task automatic t_summary();
        logic [31:0] r1;
        source_enable <= 16'hFEFB;
        summary_source <= 16'hFFFF;
        @(posedge pclk);
        summary_source <= 16'h1000;
        repeat (2) @(posedge pclk);
        chk({31'h0, summary_pending}, 32'h00000001);
        apb(1'b0, SUMMARY_ADDR, 16'h0000);
        chk(rd, 32'h0000F6FB);
        apb(1'b0, SUMMARY_ADDR, 16'h0000);
        chk(rd, 32'h00001000);
        summary_source <= 16'h0000;
        apb(1'b0, SUMMARY_ADDR, 16'h0000);
        chk(rd, 32'h00000000);
        apb(1'b1, MASK_ADDR, 16'hFFFF);
        apb(1'b0, MASK_ADDR, 16'h0000);
        chk(rd, 32'h0000F7FF);
        summary_source <= 16'h0001;
        @(posedge pclk);
        summary_source <= 16'h0000;
        repeat (3) @(posedge pclk);
        chk({31'h0, summary_pending}, 32'h00000000);
        apb(1'b1, MASK_ADDR, 16'h0000);
        repeat (3) @(posedge pclk);
        chk({31'h0, summary_pending}, 32'h00000001);
        ev_pulse = 16'h0009;
        apb(1'b0, SUMMARY_ADDR, 16'h0000);
        r1 = rd;
        ev_pulse = 16'h0000;
        apb(1'b0, SUMMARY_ADDR, 16'h0000);
        chk(r1 & 32'h00000001, 32'h00000001);
        chk({31'h0, r1[3] ^ rd[3]}, 32'h00000001);
        chk(rd & 32'h00000009, 32'h00000009);
    endtask : t_summary

    task automatic t_unmapped();
        apb(1'b0, 12'h004, 16'h0000);
        chk({31'h0, err}, 32'h00000001);
        chk(rd, 32'h00000000);
        apb(1'b1, 12'h058, 16'hFFFF);
        chk({31'h0, err}, 32'h00000001);
    endtask : t_unmapped

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_select();
        t_activity();
        t_blink();
        t_summary();
        t_unmapped();
        final_report();
    end
endmodule : tb_top
`default_nettype wire
